// file: carrier_generator_timer.sv
// Functional notes
// - High value transfer needs three count clocks
// - Counter stopped while the run bit is clear
// - Run starts count, carrier idles low
// - Low match: irq, invert, clear, select high
// - High match: irq, invert, clear, select low
// - Equal values give fifty percent duty
// - Cycle timer pulse synchronised to count clock
// - Transfer pulse copies buffer into active gate
// - Gate zero, carrier low: output low
// - Gated carrier starts at carrier rising edge
// - High pulse completes after gate falls
// - New high value latched until old match
// - Old high match still acts normally
// - Output follows remote enable and gate
// - Gate transfer at second count clock
// - Active gate read-only, buffer read-write
`timescale 1ns/1ps
`default_nettype none
module carrier_generator_timer
	import cgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cycle_timer_run,
	input wire logic cycle_timer_irq,
	output logic carrier_match_irq,
	output logic synced_gate_transfer,
	output logic carrier_out_pin
);
	function automatic logic hit_f(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
		hit_f = (cnt == cmp);
	endfunction : hit_f

	function automatic logic mapped_f(input logic [ADDR_W-1:0] a);
		mapped_f = (a == OFF_MODE) || (a == OFF_LOW) || (a == OFF_HIGH) ||
			(a == OFF_GATE) || (a == OFF_STAT);
	endfunction : mapped_f

	// Register file state.
	logic run_q, run_d;
	logic [CKS_W-1:0] cks_q, cks_d;
	logic [CNT_W-1:0] low_q, low_d, high_latch_q, high_latch_d, high_active_q, high_active_d;
	logic pend_q, pend_d;
	logic [AGE_W-1:0] age_q, age_d;
	logic gate_buf_q, gate_buf_d, gate_act_q, gate_act_d, remote_q, remote_d;

	// Counter state.
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic carrier_q, carrier_d, open_q, open_d, irq_d, out_d;
	cmp_sel_t sel_q, sel_d;

	// Bus state.
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;

	logic tick, xfer, wr_do, wr_ok, hit, hit_high;

	count_tick count_tick_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.run(run_q),
		.sel(cks_q),
		.tick_q(tick)
	);

	gate_sync gate_sync_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tick(tick),
		.irq_in(cycle_timer_irq),
		.synced_q(synced_gate_transfer),
		.xfer_q(xfer)
	);

	// AXI4-Lite slave: address and data taken in either order, one response.
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		rvalid_d = s_axi_rvalid;
		rresp_d = s_axi_rresp;
		rdata_d = s_axi_rdata;
		arready_d = s_axi_arready;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		wr_do = aw_have_q && w_have_q && !s_axi_bvalid;
		wr_ok = wr_do && mapped_f(awaddr_q) && wstrb_q[0];
		if (wr_do) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped_f(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d = !w_have_d && !bvalid_d;
		if (s_axi_arvalid && s_axi_arready) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = mapped_f(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_d = DATA_ZERO;
			if (s_axi_araddr == OFF_MODE) begin
				rdata_d[MODE_RUN_BIT] = run_q;
				rdata_d[MODE_CKS_LSB +: CKS_W] = cks_q;
			end else if (s_axi_araddr == OFF_LOW) begin
				rdata_d[CNT_W-1:0] = low_q;
			end else if (s_axi_araddr == OFF_HIGH) begin
				rdata_d[CNT_W-1:0] = high_latch_q;
			end else if (s_axi_araddr == OFF_GATE) begin
				rdata_d[GATE_BUF_BIT] = gate_buf_q;
				rdata_d[GATE_ACT_BIT] = gate_act_q;
				rdata_d[GATE_RMC_BIT] = remote_q;
			end else if (s_axi_araddr == OFF_STAT) begin
				rdata_d[STAT_CNT_LSB +: CNT_W] = cnt_q;
				rdata_d[STAT_CAR_BIT] = carrier_q;
				rdata_d[STAT_SEL_BIT] = (sel_q == SEL_HIGH);
				rdata_d[STAT_PEND_BIT] = pend_q;
				rdata_d[STAT_CYC_BIT] = cycle_timer_run;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		if (!(s_axi_arvalid && s_axi_arready) && !rvalid_d) begin
			arready_d = 1'b1;
		end
	end

	// Software-visible control, with the held high compare value.
	always_comb begin
		run_d = run_q;
		cks_d = cks_q;
		low_d = low_q;
		high_latch_d = high_latch_q;
		gate_buf_d = gate_buf_q;
		remote_d = remote_q;
		pend_d = pend_q;
		age_d = age_q;
		high_active_d = high_active_q;
		gate_act_d = xfer ? gate_buf_q : gate_act_q;
		if (tick && pend_q && age_q != HIGH_XFER_TICKS) begin
			age_d = AGE_W'(age_q + 1'b1);
		end
		if (!run_q) begin
			high_active_d = high_latch_q;
			pend_d = 1'b0;
		end else if (hit_high && pend_q && age_q == HIGH_XFER_TICKS) begin
			high_active_d = high_latch_q;
			pend_d = 1'b0;
		end
		if (wr_ok) begin
			if (awaddr_q == OFF_MODE) begin
				run_d = wdata_q[MODE_RUN_BIT];
				cks_d = wdata_q[MODE_CKS_LSB +: CKS_W];
			end else if (awaddr_q == OFF_LOW) begin
				low_d = wdata_q[CNT_W-1:0];
			end else if (awaddr_q == OFF_HIGH) begin
				high_latch_d = wdata_q[CNT_W-1:0];
				pend_d = run_q;
				age_d = AGE_RST;
			end else if (awaddr_q == OFF_GATE) begin
				gate_buf_d = wdata_q[GATE_BUF_BIT];
				remote_d = wdata_q[GATE_RMC_BIT];
			end
		end
	end

	// Alternating compare counter and gated carrier output.
	always_comb begin
		hit = run_q && tick && hit_f(cnt_q, sel_q == SEL_LOW ? low_q : high_active_q);
		hit_high = hit && (sel_q == SEL_HIGH);
		cnt_d = cnt_q;
		carrier_d = carrier_q;
		sel_d = sel_q;
		open_d = open_q;
		irq_d = hit;
		if (!run_q) begin
			cnt_d = CNT_CLEAR;
			carrier_d = 1'b0;
			sel_d = SEL_LOW;
		end else if (hit) begin
			cnt_d = CNT_CLEAR;
			carrier_d = !carrier_q;
			sel_d = (sel_q == SEL_LOW) ? SEL_HIGH : SEL_LOW;
		end else if (tick) begin
			cnt_d = CNT_W'(cnt_q + 1'b1);
		end
		// Sampling the gate only on a rising carrier edge keeps every high pulse whole.
		if (carrier_d && !carrier_q) begin
			open_d = gate_act_d;
		end else if (!carrier_d) begin
			open_d = 1'b0;
		end
		out_d = remote_d ? (carrier_d && open_d) : gate_act_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= 1'b0;
			cks_q <= CKS_RST;
			low_q <= CMP_RST;
			high_latch_q <= CMP_RST;
			high_active_q <= CMP_RST;
			pend_q <= 1'b0;
			age_q <= AGE_RST;
			gate_buf_q <= 1'b0;
			gate_act_q <= 1'b0;
			remote_q <= 1'b0;
			cnt_q <= CNT_CLEAR;
			carrier_q <= 1'b0;
			sel_q <= SEL_LOW;
			open_q <= 1'b0;
			carrier_match_irq <= 1'b0;
			carrier_out_pin <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= OFF_MODE;
			wdata_q <= DATA_ZERO;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= DATA_ZERO;
		end else if (ce) begin
			run_q <= run_d;
			cks_q <= cks_d;
			low_q <= low_d;
			high_latch_q <= high_latch_d;
			high_active_q <= high_active_d;
			pend_q <= pend_d;
			age_q <= age_d;
			gate_buf_q <= gate_buf_d;
			gate_act_q <= gate_act_d;
			remote_q <= remote_d;
			cnt_q <= cnt_d;
			carrier_q <= carrier_d;
			sel_q <= sel_d;
			open_q <= open_d;
			carrier_match_irq <= irq_d;
			carrier_out_pin <= out_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rresp <= rresp_d;
			s_axi_rdata <= rdata_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	stop_count_a: assert property (ce && !run_q |=> cnt_q == CNT_CLEAR && !carrier_q)
		else $error("counter moved while stopped");
	match_action_a: assert property (ce && hit |=> carrier_match_irq && cnt_q == CNT_CLEAR &&
		carrier_q != $past(carrier_q)) else $error("match did not clear and invert");
	sel_swap_a: assert property (ce && hit |=> sel_q != $past(sel_q))
		else $error("compare select did not alternate");
	irq_cause_a: assert property ($rose(carrier_match_irq) |-> $past(hit))
		else $error("match irq without a match");
	gate_low_a: assert property (!gate_act_q && !carrier_q |-> !carrier_out_pin)
		else $error("output high with gate and carrier low");
	high_hold_a: assert property (remote_q && $past(remote_q) && carrier_q && $past(carrier_q) &&
		$past(carrier_out_pin) |-> carrier_out_pin) else $error("high pulse cut short");
	gate_copy_a: assert property ($changed(gate_act_q) |-> $past(xfer))
		else $error("active gate changed without transfer");
	high_swap_a: assert property (run_q && $changed(high_active_q) |-> $past(hit_high))
		else $error("high compare replaced off its match");

	cover_carrier_c: cover property (run_q && remote_q ##1 $rose(carrier_out_pin));
	cover_swap_c: cover property (run_q && $changed(high_active_q));
	cover_xfer_c: cover property ($rose(gate_act_q));
endmodule : carrier_generator_timer
`default_nettype wire

// file: cgt_pkg.sv
`default_nettype none
package cgt_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CNT_W = 8;
	localparam int unsigned CKS_W = 3;
	localparam int unsigned PRESC_W = 7;
	localparam int unsigned AGE_W = 2;

	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LOW = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_HIGH = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_GATE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;

	localparam int unsigned MODE_RUN_BIT = 0;
	localparam int unsigned MODE_CKS_LSB = 1;
	localparam int unsigned GATE_BUF_BIT = 0;
	localparam int unsigned GATE_ACT_BIT = 1;
	localparam int unsigned GATE_RMC_BIT = 2;
	localparam int unsigned STAT_CNT_LSB = 0;
	localparam int unsigned STAT_CAR_BIT = 8;
	localparam int unsigned STAT_SEL_BIT = 9;
	localparam int unsigned STAT_PEND_BIT = 10;
	localparam int unsigned STAT_CYC_BIT = 11;

	localparam logic [CNT_W-1:0] CNT_CLEAR = 8'h00;
	localparam logic [CNT_W-1:0] CMP_RST = 8'h00;
	localparam logic [CKS_W-1:0] CKS_RST = 3'h0;
	localparam logic [PRESC_W-1:0] PRESC_RST = 7'h00;
	localparam logic [AGE_W-1:0] AGE_RST = 2'h0;
	localparam logic [AGE_W-1:0] HIGH_XFER_TICKS = 2'h3;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {SEL_LOW, SEL_HIGH} cmp_sel_t;
endpackage : cgt_pkg
`default_nettype wire

// file: count_tick.sv
`timescale 1ns/1ps
`default_nettype none
module count_tick
	import cgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic run,
	input wire logic [CKS_W-1:0] sel,
	output logic tick_q
);
	logic [PRESC_W-1:0] div_q, div_d, mask;
	logic tick_d;

	always_comb begin
		mask = PRESC_W'((8'h01 << sel) - 8'h01);
		// The divider restarts with the timer so the first count clock is a full period.
		div_d = run ? PRESC_W'(div_q + 1'b1) : PRESC_RST;
		tick_d = run && ((div_q & mask) == mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= PRESC_RST;
			tick_q <= 1'b0;
		end else if (ce) begin
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	tick_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !run |=> !tick_q) else $error("count clock ran while stopped");
endmodule : count_tick
`default_nettype wire

// file: gate_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gate_sync
	import cgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic tick,
	input wire logic irq_in,
	output logic synced_q,
	output logic xfer_q
);
	logic pend_q, pend_d, arm_q, arm_d, synced_d, xfer_d;

	always_comb begin
		// A request landing on the consuming tick is kept for the next one.
		pend_d = irq_in || (pend_q && !tick);
		synced_d = tick ? pend_q : synced_q;
		arm_d = tick ? synced_q : arm_q;
		// The arm flop trails the synced pulse by one count clock, so the copy lands on the second.
		xfer_d = tick && arm_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 1'b0;
			synced_q <= 1'b0;
			arm_q <= 1'b0;
			xfer_q <= 1'b0;
		end else if (ce) begin
			pend_q <= pend_d;
			synced_q <= synced_d;
			arm_q <= arm_d;
			xfer_q <= xfer_d;
		end
	end

	sync_on_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(synced_q) |-> $past(tick)) else $error("gate pulse moved off a count clock");
	cover_sync_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(synced_q));
endmodule : gate_sync
`default_nettype wire

// file: cycle_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_timer_model #(
	parameter int PERIOD = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	output logic run,
	output logic irq
);
	// The period stays far above six count clocks, so every pulse is seen by the carrier side.
	logic [7:0] cnt_q;

	assign run = en;

	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			cnt_q <= 8'h00;
			irq <= 1'b0;
		end else begin
			irq <= (cnt_q == 8'(PERIOD - 1));
			cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
		end
	end
endmodule : cycle_timer_model
`default_nettype wire

// file: carrier_generator_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module carrier_generator_timer_test
	import cgt_pkg::*;
;
	logic aclk = 1'b0;
	logic ce = 1'b1;
	logic [3:0] wstrb = 4'hF;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = 8'h00;
	logic [ADDR_W-1:0] araddr = 8'h00;
	logic [DATA_W-1:0] wdata = DATA_ZERO;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic en = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, run, irq, match_irq, synced, pin;
	logic [1:0] bresp, rresp, rsp;
	logic [DATA_W-1:0] rdata, rd;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0, t1, g;

	always #25 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	carrier_generator_timer carrier_generator_timer_i (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.cycle_timer_run(run), .cycle_timer_irq(irq), .carrier_match_irq(match_irq),
		.synced_gate_transfer(synced), .carrier_out_pin(pin));

	cycle_timer_model cycle_timer_model_i (.aclk(aclk), .aresetn(aresetn), .en(en),
		.run(run), .irq(irq));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s got %h", $time, msg, got);
			miscompares++;
		end
	endtask : chk

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
		axr(a);
		chk(rd, e, m);
	endtask : rchk

	task automatic wait_lvl(input logic v);
		do begin @(posedge aclk); end while (pin !== v);
	endtask : wait_lvl

	// Waits for a fresh rising edge so that the tail of an older pulse is not taken.
	task automatic wait_sync();
		do begin @(posedge aclk); end while (synced !== 1'b0);
		do begin @(posedge aclk); end while (synced !== 1'b1);
	endtask : wait_sync

	task automatic gap(output int n);
		n = 0;
		do begin @(posedge aclk); end while (match_irq !== 1'b1);
		do begin @(posedge aclk); n++; end while (match_irq !== 1'b1);
	endtask : gap

	// Every wait above is open ended; this limit is the only thing that ends a hang.
	initial begin
		repeat (20000) @(posedge aclk);
		$display("[FAIL] %0t watchdog expired", $time);
		miscompares++;
		end_sim();
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 5; i++) rchk(8'(i * 4), DATA_ZERO, "reset value");
		axr(8'h14);
		chk(32'(rsp), 32'(RESP_SLVERR), "unmapped read response");
		chk(rd, DATA_ZERO, "unmapped read data");
		axw(8'h14, 32'h0000_00FF);
		chk(32'(rsp), 32'(RESP_SLVERR), "unmapped write response");
		wstrb <= 4'hE;
		axw(OFF_LOW, 32'h0000_00FF);
		wstrb <= 4'hF;
		chk(32'(rsp), 32'(RESP_OKAY), "masked write response");
		rchk(OFF_LOW, DATA_ZERO, "masked write ignored");
		axw(OFF_GATE, 32'h0000_0007);
		rchk(OFF_GATE, 32'h0000_0005, "active gate not writable");
		$display("test registers done");
		axw(OFF_GATE, 32'h0000_0001);
		axw(OFF_LOW, 32'h0000_0003);
		axw(OFF_HIGH, 32'h0000_0003);
		repeat (20) @(posedge aclk);
		rchk(OFF_STAT, DATA_ZERO, "count while stopped");
		chk(32'(match_irq), 32'h0, "no match while stopped");
		$display("test stopped done");
		axw(OFF_MODE, 32'h0000_0003);
		gap(g);
		chk(32'(g), 32'h8, "equal widths first gap");
		gap(g);
		chk(32'(g), 32'h8, "equal widths second gap");
		en <= 1'b1;
		wait_sync();
		repeat (4) @(posedge aclk);
		chk(32'(pin), 32'h0, "gate copied too early");
		@(posedge aclk);
		chk(32'(pin), 32'h1, "gate high without remote");
		rchk(OFF_GATE, 32'h0000_0003, "active gate after transfer");
		axw(OFF_GATE, DATA_ZERO);
		wait_sync();
		repeat (7) @(posedge aclk);
		chk(32'(pin), 32'h0, "gate low gives low pin");
		axw(OFF_MODE, DATA_ZERO);
		en <= 1'b0;
		$display("test gate done");
		axw(OFF_GATE, 32'h0000_0005);
		axw(OFF_LOW, 32'h0000_0002);
		axw(OFF_HIGH, 32'h0000_0005);
		axw(OFF_MODE, 32'h0000_0003);
		en <= 1'b1;
		wait_sync();
		repeat (8) @(posedge aclk);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		t0 = cyc;
		wait_lvl(1'b0);
		t1 = cyc;
		chk(32'(t1 - t0), 32'd12, "carrier high width");
		wait_lvl(1'b1);
		chk(32'(cyc - t1), 32'd6, "carrier low width");
		$display("test carrier done");
		t0 = cyc;
		axw(OFF_HIGH, 32'h0000_0001);
		axr(OFF_STAT);
		chk(32'(rd[STAT_CAR_BIT +: 4]), 32'hF, "pending high value in status");
		wait_lvl(1'b0);
		chk(32'(cyc - t0), 32'd12, "old high width kept");
		wait_lvl(1'b1);
		t0 = cyc;
		wait_lvl(1'b0);
		chk(32'(cyc - t0), 32'd4, "new high width used");
		$display("test high change done");
		wait_lvl(1'b1);
		t0 = cyc;
		ce <= 1'b0;
		repeat (30) @(posedge aclk);
		chk(32'(pin), 32'h1, "pin frozen while clock enable low");
		ce <= 1'b1;
		wait_lvl(1'b0);
		chk(32'(cyc - t0), 32'd34, "high width stretched by freeze");
		$display("test clock enable done");
		end_sim();
	end
endmodule : carrier_generator_timer_test
`default_nettype wire
